// ### aurx_consts.vh
// Constants for the asynchronous serial receiver with address detection
`ifndef AURX_CONSTS_VH
`define AURX_CONSTS_VH
// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define AURX_OFF_RX_CTRL_STATUS 4'h0
`define AURX_OFF_RX_DATA 4'h1
`define AURX_OFF_TX_CTRL_STATUS 4'h2
`define AURX_OFF_BAUD_CTRL 4'h3
`define AURX_OFF_BAUD_DIV_HIGH 4'h4
`define AURX_OFF_BAUD_DIV_LOW 4'h5
`define AURX_OFF_IRQ_STATUS 4'h6
`define AURX_OFF_IRQ_MASK 4'h7
// ----------------------------------------
// Receive control/status bits
// ----------------------------------------
`define AURX_RCS_PORT_EN 7
`define AURX_RCS_NINE_BIT 6
`define AURX_RCS_CONT_RX 4
`define AURX_RCS_ADDR_DET 3
`define AURX_RCS_FRAMING 2
`define AURX_RCS_OVERRUN 1
`define AURX_RCS_NINTH 0
`define AURX_RCS_WR_MASK 8'hf8
// ----------------------------------------
// Transmit control, baud control bits
// ----------------------------------------
`define AURX_TCS_MODE_SYNC 4
`define AURX_TCS_HIGH_SPEED 2
`define AURX_TCS_RESET 8'h02
`define AURX_TCS_WR_MASK 8'hfd
`define AURX_BC_RX_IDLE 6
`define AURX_BC_POL_INV 5
`define AURX_BC_WIDE_BAUD 3
`define AURX_BC_WR_MASK 8'hba
`define AURX_BC_RD_MASK 8'hfb
// ----------------------------------------
// Interrupt status bits
// ----------------------------------------
`define AURX_IRQ_RX_READY 0
`define AURX_IRQ_OVERRUN 1
`define AURX_IRQ_FRAMING 2
`define AURX_IRQ_WIDTH 3
// ----------------------------------------
// Receiver timing
// ----------------------------------------
`define AURX_OVERSAMPLE 5'd16
`define AURX_HALF_BIT 4'd7
`define AURX_LAST_TICK 4'hf
`define AURX_LAST_BIT_NINE 4'd8
`define AURX_LAST_BIT_EIGHT 4'd7
`endif

// ### aurx_top.v
// Asynchronous serial receive path with two-character buffer and Avalon-MM registers
//
// Contract
// - Two-character buffer; third character sets overrun
// - Overrun keeps buffer readable, blocks new characters
// - Overrun cleared by clearing receive or port enable
// - Nine-bit select shifts nine data bits
// - Ninth bit shows oldest unread character
// - Address mode keeps only ninth-bit-set characters
// - Ready flag on buffer load; irq if enabled
// - Address mode characters report ninth bit one
// - Start on fall, abort if mid-start high
// - Ready flag read-only, set while receive enabled and data unread
// - Per-character framing bit, oldest reported only
module aurx_top #(
  parameter DEPTH = 2
) (
  input wire clock,
  input wire rstn,
  input wire [3:0] address,
  input wire read,
  input wire write,
  input wire [31:0] writedata,
  output reg [31:0] readdata,
  output wire waitrequest,
  input wire rx_line_pin,
  output wire rx_irq
);
`include "aurx_consts.vh"
  // ----------------------------------------
  // Registers
  // ----------------------------------------
  reg [7:0] rcs_reg;
  reg [7:0] tcs_reg;
  reg [7:0] bc_reg;
  reg [7:0] div_hi_reg;
  reg [7:0] div_lo_reg;
  reg [2:0] irq_stat_reg;
  reg [2:0] irq_mask_reg;
  reg overrun_reg;
  reg ack_reg;
  reg [2:0] sync_reg;
  reg line_reg;
  reg line_prev_reg;
  reg [1:0] state_reg;
  reg [15:0] brg_reg;
  reg [3:0] tick_reg;
  reg [3:0] bit_reg;
  reg [8:0] shift_reg;
  reg [1:0] cnt_reg;
  reg rd_ptr_reg;
  reg wr_ptr_reg;
  reg [8:0] buf_data [0:DEPTH-1];
  reg buf_framing_flag [0:DEPTH-1];
  localparam ST_IDLE = 2'd0;
  localparam ST_START = 2'd1;
  localparam ST_DATA = 2'd2;
  localparam ST_STOP = 2'd3;

  wire port_en = rcs_reg[`AURX_RCS_PORT_EN];
  wire nine = rcs_reg[`AURX_RCS_NINE_BIT];
  wire rx_en = port_en & rcs_reg[`AURX_RCS_CONT_RX] & ~tcs_reg[`AURX_TCS_MODE_SYNC];
  wire addr_mode = nine & rcs_reg[`AURX_RCS_ADDR_DET];
  wire bus_wr = write & ack_reg;
  wire bus_rd = read & ack_reg;
  // One wait state per access keeps read data registered
  assign waitrequest = (read | write) & ~ack_reg;

  // ----------------------------------------
  // Line sampling and baud tick
  // ----------------------------------------
  // Divisor: 8-bit or 16-bit; high speed bit is kept but the divisor alone sets the tick
  wire [15:0] div_val = bc_reg[`AURX_BC_WIDE_BAUD] ? {div_hi_reg, div_lo_reg} : {8'h00, div_lo_reg};
  wire brg_tick = (brg_reg == 16'h0000);
  wire div_wr = bus_wr & ((address == `AURX_OFF_BAUD_DIV_HIGH) | (address == `AURX_OFF_BAUD_DIV_LOW));
  wire line_in = line_reg ^ bc_reg[`AURX_BC_POL_INV];
  wire [1:0] cnt_full = DEPTH[1:0];
  wire buf_full = (cnt_reg == cnt_full);
  wire last_bit = nine ? (bit_reg == `AURX_LAST_BIT_NINE) : (bit_reg == `AURX_LAST_BIT_EIGHT);
  // Stop judged at mid-bit, on the same tick that returns to idle
  wire stop_now = (state_reg == ST_STOP) & brg_tick & (tick_reg == `AURX_LAST_TICK);
  // a held-low line must not restart reception
  wire fall_edge = line_prev_reg & ~line_in;
  wire keep = ~addr_mode | shift_reg[8];
  wire do_pop = bus_rd & (address == `AURX_OFF_RX_DATA) & (cnt_reg != 2'd0);
  wire rcs_wr = bus_wr & (address == `AURX_OFF_RX_CTRL_STATUS);
  // overrun drops on the write of a zero enable
  wire ovr_clr = ~rcs_reg[`AURX_RCS_CONT_RX] | (rcs_wr & ~writedata[`AURX_RCS_CONT_RX]);
  wire load_ok = stop_now & keep & ~overrun_reg;
  wire do_push = load_ok & ~buf_full;
  wire set_ovr = load_ok & buf_full;

  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      sync_reg <= 3'h7;
      line_reg <= 1'b1;
      line_prev_reg <= 1'b1;
      brg_reg <= 16'h0000;
    end else begin
      sync_reg <= {sync_reg[1:0], rx_line_pin};
      if (sync_reg[2] == sync_reg[1])
        line_reg <= sync_reg[2];
      line_prev_reg <= line_in;
      // Reload on divisor write so a new rate starts clean
      if (div_wr | brg_tick | ~port_en)
        brg_reg <= div_val;
      else
        brg_reg <= brg_reg - 16'h0001;
    end
  end

  // ----------------------------------------
  // Receive state machine
  // ----------------------------------------
  // Sixteen ticks per bit; the prescale choice is folded into the divisor
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state_reg <= ST_IDLE;
      tick_reg <= 4'h0;
      bit_reg <= 4'h0;
      shift_reg <= 9'h000;
    end else if (!rx_en) begin
      state_reg <= ST_IDLE;
      tick_reg <= 4'h0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          tick_reg <= 4'h0;
          if (fall_edge)
            state_reg <= ST_START;
        end
        ST_START: begin
          if (brg_tick) begin
            tick_reg <= tick_reg + 4'h1;
            if (tick_reg == `AURX_HALF_BIT) begin
              tick_reg <= 4'h0;
              bit_reg <= 4'h0;
              state_reg <= line_in ? ST_IDLE : ST_DATA;
            end
          end
        end
        ST_DATA: begin
          if (brg_tick) begin
            tick_reg <= tick_reg + 4'h1;
            if (tick_reg == `AURX_LAST_TICK) begin
              // eight or nine bits, LSB first
              shift_reg <= nine ? {line_in, shift_reg[8:1]} : {1'b0, line_in, shift_reg[7:1]};
              bit_reg <= bit_reg + 4'h1;
              if (last_bit)
                state_reg <= ST_STOP;
            end
          end
        end
        ST_STOP: begin
          if (brg_tick) begin
            tick_reg <= tick_reg + 4'h1;
            if (tick_reg == `AURX_LAST_TICK)
              state_reg <= ST_IDLE;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // Receive buffer
  // ----------------------------------------
  // Slots are not reset; the count guards every read of them
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      cnt_reg <= 2'd0;
      rd_ptr_reg <= 1'b0;
      wr_ptr_reg <= 1'b0;
      overrun_reg <= 1'b0;
    end else if (!port_en) begin
      cnt_reg <= 2'd0;
      rd_ptr_reg <= 1'b0;
      wr_ptr_reg <= 1'b0;
      overrun_reg <= 1'b0;
    end else begin
      if (set_ovr)
        overrun_reg <= 1'b1;
      else if (ovr_clr)
        overrun_reg <= 1'b0;
      if (do_push)
        wr_ptr_reg <= ~wr_ptr_reg;
      // buffered data stays readable under overrun
      if (do_pop)
        rd_ptr_reg <= ~rd_ptr_reg;
      cnt_reg <= cnt_reg + {1'b0, do_push} - {1'b0, do_pop};
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < DEPTH; gi = gi + 1) begin : g_buf
      always @(posedge clock) begin
        if (do_push && wr_ptr_reg == gi) begin
          buf_data[gi] <= shift_reg;
          buf_framing_flag[gi] <= ~line_in;
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // Status views
  // ----------------------------------------
  // ready while enabled and data unread
  wire rx_ready = rx_en & (cnt_reg != 2'd0);
  // Empty buffer reads zero
  wire [8:0] top_data = (cnt_reg != 2'd0) ? buf_data[rd_ptr_reg] : 9'h000;
  wire top_framing_flag = (cnt_reg != 2'd0) ? buf_framing_flag[rd_ptr_reg] : 1'b0;
  // ninth bit of oldest; holds by the filter
  wire [7:0] rcs_view = {rcs_reg[7:3], top_framing_flag, overrun_reg, top_data[8]};
  wire rx_idle = (state_reg == ST_IDLE);
  wire [7:0] bc_view = {1'b0, rx_idle, bc_reg[5:0]} & `AURX_BC_RD_MASK;
  // live ready level beside the sticky bits
  wire [7:0] irq_view = {4'h0, rx_ready, irq_stat_reg};

  // ----------------------------------------
  // Interrupt flags
  // ----------------------------------------
  wire buf_framing_flag_next = ~line_in;
  wire [`AURX_IRQ_WIDTH-1:0] irq_events;
  assign irq_events[`AURX_IRQ_RX_READY] = do_push;
  assign irq_events[`AURX_IRQ_OVERRUN] = set_ovr;
  assign irq_events[`AURX_IRQ_FRAMING] = do_push & buf_framing_flag_next;
  // Write one to clear
  wire [2:0] irq_clr = (bus_wr && address == `AURX_OFF_IRQ_STATUS) ? writedata[2:0] : 3'h0;
  wire [`AURX_IRQ_WIDTH-1:0] irq_stat_next;
  genvar ii;
  generate
    for (ii = 0; ii < `AURX_IRQ_WIDTH; ii = ii + 1) begin : g_irq
      // sticky event; set wins over clear
      assign irq_stat_next[ii] = irq_events[ii] | (irq_stat_reg[ii] & ~irq_clr[ii]);
    end
  endgenerate
  assign rx_irq = |(irq_stat_reg & irq_mask_reg);

  // ----------------------------------------
  // Avalon-MM slave
  // ----------------------------------------
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ack_reg <= 1'b0;
      readdata <= 32'h00000000;
      rcs_reg <= 8'h00;
      tcs_reg <= `AURX_TCS_RESET;
      bc_reg <= 8'h00;
      div_hi_reg <= 8'h00;
      div_lo_reg <= 8'h00;
      irq_stat_reg <= 3'h0;
      irq_mask_reg <= 3'h0;
    end else begin
      ack_reg <= (read | write) & ~ack_reg;
      irq_stat_reg <= irq_stat_next;
      if (bus_wr) begin
        case (address)
          `AURX_OFF_RX_CTRL_STATUS: rcs_reg <= writedata[7:0] & `AURX_RCS_WR_MASK;
          `AURX_OFF_TX_CTRL_STATUS: tcs_reg <= (writedata[7:0] & `AURX_TCS_WR_MASK) | `AURX_TCS_RESET;
          `AURX_OFF_BAUD_CTRL: bc_reg <= writedata[7:0] & `AURX_BC_WR_MASK;
          `AURX_OFF_BAUD_DIV_HIGH: div_hi_reg <= writedata[7:0];
          `AURX_OFF_BAUD_DIV_LOW: div_lo_reg <= writedata[7:0];
          `AURX_OFF_IRQ_MASK: irq_mask_reg <= writedata[2:0];
          default: ;
        endcase
      end
      if (read & ~ack_reg) begin
        case (address)
          `AURX_OFF_RX_CTRL_STATUS: readdata <= {24'h000000, rcs_view};
          `AURX_OFF_RX_DATA: readdata <= {24'h000000, top_data[7:0]};
          `AURX_OFF_TX_CTRL_STATUS: readdata <= {24'h000000, tcs_reg};
          `AURX_OFF_BAUD_CTRL: readdata <= {24'h000000, bc_view};
          `AURX_OFF_BAUD_DIV_HIGH: readdata <= {24'h000000, div_hi_reg};
          `AURX_OFF_BAUD_DIV_LOW: readdata <= {24'h000000, div_lo_reg};
          `AURX_OFF_IRQ_STATUS: readdata <= {24'h000000, irq_view};
          `AURX_OFF_IRQ_MASK: readdata <= {29'h0, irq_mask_reg};
          default: readdata <= 32'h00000000;
        endcase
      end
    end
  end
endmodule

// ### aurx_line_model.sv
// Remote serial transmitter model driving the receive line
module aurx_line_model (
  input wire clock,
  output logic line
);
  timeunit 1ns;
  timeprecision 1ns;
  // Divisor 0 gives sixteen clocks a bit
  localparam int BIT = 16;
  initial line = 1'b1;
  // ----------------------------------------
  // Framing
  // ----------------------------------------
  // start low, data LSB first, stop
  task automatic send(input logic [8:0] d, input logic nine, input logic stop);
    logic [10:0] f;
    f = nine ? {stop, d, 1'b0} : {1'b1, stop, d[7:0], 1'b0};
    for (int i = 0; i < 11; i++) begin
      line <= f[i];
      repeat (BIT) @(posedge clock);
    end
    // Idle gap so a bad stop still leaves a falling edge
    line <= 1'b1;
    repeat (BIT) @(posedge clock);
  endtask
  // short low pulse, no start bit
  task automatic glitch();
    line <= 1'b0;
    repeat (4) @(posedge clock);
    line <= 1'b1;
    repeat (40) @(posedge clock);
  endtask
endmodule

// ### aurx_top_asserts.sv
// Port checker for the serial receive path
module aurx_top_asserts #(
  parameter DEPTH = 2
) (
  input wire clock,
  input wire rstn,
  input wire [3:0] address,
  input wire read,
  input wire write,
  input wire [31:0] writedata,
  input wire [31:0] readdata,
  input wire waitrequest,
  input wire rx_line_pin,
  input wire rx_irq
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  sequence req_held;
    (read || write) && waitrequest;
  endsequence
  sequence rd_done;
    read && !waitrequest;
  endsequence
  wait_first_a: assert property ($rose(read || write) |-> waitrequest)
    else $error("no wait state");
  wait_once_a: assert property (req_held |=> !waitrequest)
    else $error("wait too long");
  unmapped_zero_a: assert property (rd_done ##0 address[3] |-> readdata == 32'h0)
    else $error("unmapped read not zero");
  upper_zero_a: assert property (rd_done |-> readdata[31:8] == 24'h0)
    else $error("high bits set");
  tx_fixed_a: assert property (rd_done ##0 address == 4'h2 |-> readdata[1])
    else $error("tx status bit low");
  ctrl_gap_a: assert property (rd_done ##0 address == 4'h0 |-> !readdata[5])
    else $error("ctrl gap bit set");
  data_hold_a: assert property (!(read && waitrequest) |=> $stable(readdata))
    else $error("readdata moved");
  irq_fall_a: assert property ($fell(rx_irq) |-> $past(write && !waitrequest))
    else $error("irq fell without write");
endmodule
bind aurx_top aurx_top_asserts #(.DEPTH(DEPTH)) chk (.clock(clock), .rstn(rstn), .address(address),
  .read(read), .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
  .rx_line_pin(rx_line_pin), .rx_irq(rx_irq));

// ### test_async_uart_receive_errors_addr_detect.sv
// Self-checking bench for the serial receive path
module test_async_uart_receive_errors_addr_detect;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 0, rstn = 0, read = 0, write = 0;
  logic [3:0] address = 0;
  logic [31:0] writedata = 0;
  wire [31:0] readdata;
  wire waitrequest, rx_line_pin, rx_irq;
  logic [31:0] exp_q[$];
  string nam_q[$];
  int errors = 0, n_compared = 0;
  logic [7:0] d[6];
  always #5 clock = ~clock;
  aurx_top uut (.clock(clock), .rstn(rstn), .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest), .rx_line_pin(rx_line_pin),
    .rx_irq(rx_irq));
  aurx_line_model far (.clock(clock), .line(rx_line_pin));
  task automatic check(string n, logic [31:0] seen, logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic print_verdict();
    if (exp_q.size() != 0) errors++;
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // ----------------------------------------
  // Bus access, read expectations queued
  // ----------------------------------------
  task automatic bus(logic rd, logic [3:0] a, logic [7:0] v, string n);
    address <= a;
    read <= rd;
    write <= !rd;
    writedata <= {24'h0, v};
    if (rd) begin
      exp_q.push_back({24'h0, v});
      nam_q.push_back(n);
    end
    // Request held until waitrequest is sampled low at a rising edge
    do @(posedge clock); while (waitrequest !== 1'b0);
    read <= 0;
    write <= 0;
    @(posedge clock);
  endtask
  always @(posedge clock) begin
    if (read && !waitrequest && exp_q.size() > 0) check(nam_q.pop_front(), readdata, exp_q.pop_front());
  end
  initial begin
    void'($urandom(13));
    foreach (d[i]) d[i] = $urandom;
    repeat (2) @(posedge clock);
    rstn <= 1;
    @(posedge clock);
    // baud and mode first, reception last
    bus(0, 4'h5, 8'h00, "");
    bus(0, 4'h2, 8'h00, "");
    bus(1, 4'h2, 8'h02, "tx");
    bus(1, 4'h9, 8'h00, "gap");
    bus(0, 4'h0, 8'h80, "");
    bus(0, 4'h0, 8'h90, "");
    far.send({1'b0, d[0]}, 0, 1);
    far.send({1'b0, d[1]}, 0, 0);
    far.send({1'b0, d[2]}, 0, 1);
    check("irq", rx_irq, 0);
    bus(0, 4'h7, 8'h01, "");
    check("irq", rx_irq, 1);
    bus(1, 4'h6, 8'h0f, "irq status");
    // status read before data, per character
    bus(1, 4'h0, 8'h92, "ctrl");
    bus(1, 4'h1, d[0], "data");
    bus(1, 4'h0, 8'h96, "ctrl");
    bus(1, 4'h1, d[1], "data");
    bus(1, 4'h1, 8'h00, "data");
    far.send({1'b0, d[3]}, 0, 1);
    bus(1, 4'h1, 8'h00, "data");
    bus(1, 4'h6, 8'h07, "irq status");
    bus(0, 4'h6, 8'h07, "");
    check("irq", rx_irq, 0);
    // receive enable toggled to end overrun
    bus(0, 4'h0, 8'h80, "");
    bus(1, 4'h0, 8'h80, "ctrl");
    bus(0, 4'h0, 8'h90, "");
    far.send({1'b0, d[4]}, 0, 1);
    bus(1, 4'h0, 8'h90, "ctrl");
    bus(1, 4'h1, d[4], "data");
    far.glitch();
    far.send({1'b0, d[5]}, 0, 1);
    bus(1, 4'h1, d[5], "data");
    // ----------------------------------------
    // Nine-bit and address modes
    // ----------------------------------------
    bus(0, 4'h0, 8'hd0, "");
    far.send({1'b1, d[0]}, 1, 1);
    far.send({1'b0, d[1]}, 1, 1);
    bus(1, 4'h0, 8'hd1, "ctrl");
    bus(1, 4'h1, d[0], "data");
    bus(1, 4'h0, 8'hd0, "ctrl");
    bus(1, 4'h1, d[1], "data");
    bus(0, 4'h0, 8'hc8, "");
    bus(0, 4'h0, 8'hd8, "");
    far.send({1'b0, d[2]}, 1, 1);
    far.send({1'b1, d[3]}, 1, 1);
    bus(1, 4'h0, 8'hd9, "ctrl");
    bus(1, 4'h1, d[3], "data");
    bus(1, 4'h1, 8'h00, "data");
    bus(0, 4'h0, 8'hd0, "");
    far.send({1'b0, d[4]}, 1, 1);
    bus(1, 4'h1, d[4], "data");
    // message over, back to address mode
    bus(0, 4'h0, 8'hd8, "");
    far.send({1'b0, d[5]}, 1, 1);
    bus(1, 4'h1, 8'h00, "data");
    print_verdict();
  end
  // Roughly two and a half thousand cycles expected
  initial begin
    repeat (20000) @(posedge clock);
    errors++;
    print_verdict();
  end
endmodule
